// ==== core/jlp_cfg_reg.sv ====
// One byte-wide software configuration register with a reset value and a write mask.
`default_nettype none

module jlp_cfg_reg
   import jlp_pkg::*;
#(
   parameter jlp_byte_t RESET_VAL = 8'h00,
   parameter jlp_byte_t WMASK = 8'hff
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic [7:0] value
);

   logic [7:0] value_q;
   logic [7:0] value_d;

   // Bits outside the mask keep their reset value, so they read back as constants.
   always_comb begin
      value_d = value_q;
      if (wr_en) begin
         value_d = (wdata & WMASK) | (value_q & ~WMASK);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         value_q <= RESET_VAL;
      end else begin
         value_q <= value_d;
      end
   end

   assign value = value_q;

endmodule : jlp_cfg_reg

`default_nettype wire

// ==== core/jlp_lane_start.sv ====
// Run enables for the per-lane buffers between framer and transmitter PHY.
`default_nettype none

module jlp_lane_start
   import jlp_pkg::*;
#(
   parameter int LANES = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [4:0] lane_count,
   output logic [LANES-1:0] lane_run,
   output logic start_pulse
);

   logic [LANES-1:0] run_q;
   logic [LANES-1:0] run_d;
   logic start_prev_q;
   logic start_prev_d;
   logic pulse_q;
   logic pulse_d;

   // A lane runs only while the buffers are started and the lane count covers it.
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         run_d[i] = start && (lane_count >= 5'(i));
      end
      start_prev_d = start;
      pulse_d = start && !start_prev_q;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_q <= '0;
         start_prev_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         run_q <= run_d;
         start_prev_q <= start_prev_d;
         pulse_q <= pulse_d;
      end
   end

   assign lane_run = run_q;
   assign start_pulse = pulse_q;

endmodule : jlp_lane_start

`default_nettype wire

// ==== core/jlp_link_param_regs.sv ====
// Link parameter register bank for the serial transmit framer, Avalon-MM slave.
//
// Functional notes
// - Five-bit lane count, reset one lane.
// - Scrambling enable in bit seven, reset off.
// - Octets per frame code, reset four.
// - Frames per multiframe is value plus one.
// - Converter count register resets to two converters.
// - Writable device identifier byte, reset zero.
// - Bank identifier low nibble, upper nibble read-only.
// - Separate five-bit lane identifiers, resets zero, one.
// - Per-lane checksum bytes, resets 0x44 and 0x45.
// - Start bit starts the per-lane buffers.
// - Two spare writable parameter bytes, reset zero.
`include "jlp_params.svh"
`default_nettype none

module jlp_link_param_regs
   import jlp_pkg::*;
#(
   parameter int LANES = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [`JLP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`JLP_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [`JLP_DATA_W-1:0] avs_readdata,
   output logic [1:0] avs_response,
   output logic avs_waitrequest,
   // The framer reads these levels at any time.
   output logic [7:0] cfg_device_id,
   output logic [3:0] cfg_bank_id,
   output logic [4:0] cfg_lane_count,
   output logic cfg_scramble_en,
   output logic [7:0] cfg_octets_per_frame,
   output logic [4:0] cfg_frames_per_multiframe,
   output logic [7:0] cfg_converter_count,
   output logic [4:0] cfg_samples_per_frame,
   output logic [7:0] cfg_spare_param_byte_one,
   output logic [7:0] cfg_spare_param_byte_two,
   output logic [4:0] cfg_lane0_id,
   output logic [4:0] cfg_lane1_id,
   output logic [7:0] cfg_lane0_checksum,
   output logic [7:0] cfg_lane1_checksum,
   // These start and report the lane buffers.
   output logic lane_buffer_start,
   output logic [LANES-1:0] lane_buffer_run,
   output logic lane_buffer_start_pulse
);

   // ****************************************************************
   // Bus handshake
   // ****************************************************************

   // Every access takes one wait state: the first cycle decodes and loads the
   // read data, the second drops waitrequest. The extra cycle keeps read data
   // straight from a flip-flop at the cost of bus throughput.
   jlp_bus_state_t state_q;
   jlp_bus_state_t state_d;

   logic [`JLP_DATA_W-1:0] rdata_q;
   logic [`JLP_DATA_W-1:0] rdata_d;

   logic [1:0] resp_q;
   logic [1:0] resp_d;

   logic req;
   logic wr_fire;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] wbyte;

   assign req = avs_read || avs_write;
   assign wbyte = avs_writedata[7:0];

   // Writes land on the edge where waitrequest is low; narrow registers sit in
   // byte lane zero, so a write without that lane enabled changes nothing.
   assign wr_fire = avs_write && (state_q == JLP_BUS_ANSWER) && avs_byteenable[0];

   // ****************************************************************
   // Register storage
   // ****************************************************************

   logic [7:0] device_id_q;
   logic [7:0] bank_id_q;
   logic [7:0] lane_cnt_q;
   logic [7:0] octets_q;
   logic [7:0] frames_mf_q;
   logic [7:0] conv_cnt_q;
   logic [7:0] samples_q;

   logic [7:0] spare_one_q;
   logic [7:0] spare_two_q;

   logic [7:0] lane0_id_q;
   logic [7:0] lane1_id_q;
   logic [7:0] lane0_chk_q;
   logic [7:0] lane1_chk_q;

   logic [7:0] buf_start_q;

   logic [LANES-1:0] run_q;
   logic pulse_q;

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_DEVICE_ID), .WMASK(`JLP_WMASK_ALL)) u_device_id (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_DEVICE_ID)),
      .wdata(wbyte),
      .value(device_id_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_BANK_ID), .WMASK(`JLP_WMASK_BANK_ID)) u_bank_id (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_BANK_ID)),
      .wdata(wbyte),
      .value(bank_id_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_LANE_CNT), .WMASK(`JLP_WMASK_ALL)) u_lane_cnt (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_LANE_CNT)),
      .wdata(wbyte),
      .value(lane_cnt_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_OCTETS), .WMASK(`JLP_WMASK_ALL)) u_octets (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_OCTETS)),
      .wdata(wbyte),
      .value(octets_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_FRAMES_MF), .WMASK(`JLP_WMASK_ALL)) u_frames_mf (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_FRAMES_MF)),
      .wdata(wbyte),
      .value(frames_mf_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_CONV_CNT), .WMASK(`JLP_WMASK_ALL)) u_conv_cnt (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_CONV_CNT)),
      .wdata(wbyte),
      .value(conv_cnt_q)
   );

   // Only zero is meaningful here; other values are stored as written and are
   // passed on cut to their low five bits, so a wrong setting is visible on readback.
   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_SAMPLES), .WMASK(`JLP_WMASK_ALL)) u_samples (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_SAMPLES)),
      .wdata(wbyte),
      .value(samples_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_SPARE), .WMASK(`JLP_WMASK_ALL)) u_spare_one (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_SPARE_ONE)),
      .wdata(wbyte),
      .value(spare_one_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_SPARE), .WMASK(`JLP_WMASK_ALL)) u_spare_two (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_SPARE_TWO)),
      .wdata(wbyte),
      .value(spare_two_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_LANE0_ID), .WMASK(`JLP_WMASK_ALL)) u_lane0_id (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_LANE0_ID)),
      .wdata(wbyte),
      .value(lane0_id_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_LANE1_ID), .WMASK(`JLP_WMASK_ALL)) u_lane1_id (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_LANE1_ID)),
      .wdata(wbyte),
      .value(lane1_id_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_LANE0_CHK), .WMASK(`JLP_WMASK_ALL)) u_lane0_chk (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_LANE0_CHK)),
      .wdata(wbyte),
      .value(lane0_chk_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_LANE1_CHK), .WMASK(`JLP_WMASK_ALL)) u_lane1_chk (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_LANE1_CHK)),
      .wdata(wbyte),
      .value(lane1_chk_q)
   );

   jlp_cfg_reg #(.RESET_VAL(`JLP_RST_BUF_START), .WMASK(`JLP_WMASK_ALL)) u_buf_start (
      .mclk(mclk),
      .rstn(rstn),
      .wr_en(wr_fire && (avs_address == `JLP_IDX_BUF_START)),
      .wdata(wbyte),
      .value(buf_start_q)
   );

   // ****************************************************************
   // Lane buffer start
   // ****************************************************************

   // Software is expected to finish configuration before setting the start bit;
   // nothing here locks the parameters, so late changes reach the framer at once.
   jlp_lane_start #(.LANES(LANES)) u_lane_start (
      .mclk(mclk),
      .rstn(rstn),
      .start(buf_start_q[`JLP_BUF_START_BIT]),
      .lane_count(lane_cnt_q[`JLP_LANE_CNT_MSB:0]),
      .lane_run(run_q),
      .start_pulse(pulse_q)
   );

   // ****************************************************************
   // Read decode
   // ****************************************************************

   // An unmapped index reads zero and answers with an error.
   always_comb begin
      hit = 1'b1;
      rd_byte = 8'h00;
      case (avs_address)
         `JLP_IDX_DEVICE_ID: rd_byte = device_id_q;
         `JLP_IDX_BANK_ID: rd_byte = bank_id_q;
         `JLP_IDX_LANE_CNT: rd_byte = lane_cnt_q;
         `JLP_IDX_OCTETS: rd_byte = octets_q;
         `JLP_IDX_FRAMES_MF: rd_byte = frames_mf_q;
         `JLP_IDX_CONV_CNT: rd_byte = conv_cnt_q;
         `JLP_IDX_SAMPLES: rd_byte = samples_q;
         `JLP_IDX_SPARE_ONE: rd_byte = spare_one_q;
         `JLP_IDX_SPARE_TWO: rd_byte = spare_two_q;
         `JLP_IDX_LANE0_ID: rd_byte = lane0_id_q;
         `JLP_IDX_LANE1_ID: rd_byte = lane1_id_q;
         `JLP_IDX_LANE0_CHK: rd_byte = lane0_chk_q;
         `JLP_IDX_LANE1_CHK: rd_byte = lane1_chk_q;
         `JLP_IDX_BUF_START: rd_byte = buf_start_q;
         `JLP_IDX_LANE_STATUS: rd_byte = 8'(run_q);
         default: hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Bus state
   // ****************************************************************

   always_comb begin
      state_d = state_q;
      rdata_d = rdata_q;
      resp_d = resp_q;
      case (state_q)
         JLP_BUS_IDLE: begin
            if (req) begin
               state_d = JLP_BUS_ANSWER;
               rdata_d = avs_read ? {24'h000000, rd_byte} : '0;
               // The status word is read-only, so a write to it is refused.
               if (!hit || (avs_write && (avs_address == `JLP_IDX_LANE_STATUS))) begin
                  resp_d = `JLP_RESP_SLVERR;
               end else begin
                  resp_d = `JLP_RESP_OKAY;
               end
            end
         end
         JLP_BUS_ANSWER: begin
            state_d = JLP_BUS_IDLE;
         end
         default: begin
            state_d = JLP_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= JLP_BUS_IDLE;
         rdata_q <= '0;
         resp_q <= `JLP_RESP_OKAY;
      end else begin
         state_q <= state_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
      end
   end

   // One wait state per access, whatever the request.
   assign avs_waitrequest = req && (state_q != JLP_BUS_ANSWER);
   assign avs_readdata = rdata_q;
   assign avs_response = resp_q;

   // ****************************************************************
   // Framer configuration outputs
   // ****************************************************************

   assign cfg_device_id = device_id_q;
   assign cfg_bank_id = bank_id_q[`JLP_BANK_ID_MSB:0];
   assign cfg_lane_count = lane_cnt_q[`JLP_LANE_CNT_MSB:0];
   assign cfg_scramble_en = lane_cnt_q[`JLP_SCRAMBLE_BIT];
   assign cfg_octets_per_frame = octets_q;
   assign cfg_frames_per_multiframe = frames_mf_q[`JLP_LANE_CNT_MSB:0];
   assign cfg_converter_count = conv_cnt_q;

   assign cfg_samples_per_frame = samples_q[`JLP_ID5_MSB:0];
   assign cfg_spare_param_byte_one = spare_one_q;
   assign cfg_spare_param_byte_two = spare_two_q;

   assign cfg_lane0_id = lane0_id_q[`JLP_ID5_MSB:0];
   assign cfg_lane1_id = lane1_id_q[`JLP_ID5_MSB:0];
   assign cfg_lane0_checksum = lane0_chk_q;
   assign cfg_lane1_checksum = lane1_chk_q;

   assign lane_buffer_start = buf_start_q[`JLP_BUF_START_BIT];
   assign lane_buffer_run = run_q;
   assign lane_buffer_start_pulse = pulse_q;

endmodule : jlp_link_param_regs

`default_nettype wire

// ==== core/jlp_params.svh ====
// Register indices, field positions and reset values of the link parameter bank.
`ifndef JLP_PARAMS_SVH
`define JLP_PARAMS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define JLP_ADDR_W 10
`define JLP_DATA_W 32
`define JLP_REG_W 8

// ****************************************************************
// Register indices (word address on the bus, byte address is four times this)
// ****************************************************************
`define JLP_IDX_DEVICE_ID 10'h1c0
`define JLP_IDX_BANK_ID 10'h1c1
`define JLP_IDX_LANE_CNT 10'h1c3
`define JLP_IDX_OCTETS 10'h1c4
`define JLP_IDX_FRAMES_MF 10'h1c5
`define JLP_IDX_CONV_CNT 10'h1c6
`define JLP_IDX_SAMPLES 10'h1c9
`define JLP_IDX_SPARE_ONE 10'h1cb
`define JLP_IDX_SPARE_TWO 10'h1cc
`define JLP_IDX_LANE0_ID 10'h1d0
`define JLP_IDX_LANE1_ID 10'h1d1
`define JLP_IDX_LANE0_CHK 10'h1d8
`define JLP_IDX_LANE1_CHK 10'h1d9
`define JLP_IDX_BUF_START 10'h1e0
`define JLP_IDX_LANE_STATUS 10'h1ef

// ****************************************************************
// Reset values
// ****************************************************************
`define JLP_RST_DEVICE_ID 8'h00
`define JLP_RST_BANK_ID 8'h00
`define JLP_RST_LANE_CNT 8'h00
`define JLP_RST_OCTETS 8'h03
`define JLP_RST_FRAMES_MF 8'h1f
`define JLP_RST_CONV_CNT 8'h01
`define JLP_RST_SAMPLES 8'h00
`define JLP_RST_SPARE 8'h00
`define JLP_RST_LANE0_ID 8'h00
`define JLP_RST_LANE1_ID 8'h01
`define JLP_RST_LANE0_CHK 8'h44
`define JLP_RST_LANE1_CHK 8'h45
`define JLP_RST_BUF_START 8'h00

// ****************************************************************
// Write masks and fields
// ****************************************************************
`define JLP_WMASK_ALL 8'hff
`define JLP_WMASK_BANK_ID 8'h0f
`define JLP_LANE_CNT_MSB 4
`define JLP_SCRAMBLE_BIT 7
`define JLP_ID5_MSB 4
`define JLP_BANK_ID_MSB 3
`define JLP_BUF_START_BIT 0
`define JLP_LANES_TWO 5'h01

// ****************************************************************
// Bus answer codes
// ****************************************************************
`define JLP_RESP_OKAY 2'h0
`define JLP_RESP_SLVERR 2'h2

`endif

// ==== core/jlp_pkg.sv ====
// Types shared by the link parameter bank.
`default_nettype none

package jlp_pkg;

   typedef enum logic [0:0] {
      JLP_BUS_IDLE,
      JLP_BUS_ANSWER
   } jlp_bus_state_t;

   typedef logic [7:0] jlp_byte_t;

endpackage : jlp_pkg

`default_nettype wire

// ==== dv/jlp_framer_model.sv ====
// Framer stand-in that latches the link setup each time the lane buffers start.
`default_nettype none

module jlp_framer_model
   import jlp_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [4:0] cfg_lane_count,
   input wire logic [7:0] cfg_octets_per_frame,
   input wire logic [4:0] cfg_frames_per_multiframe,
   input wire logic lane_buffer_start_pulse,
   output logic [5:0] frames_seen,
   output logic [2:0] octets_seen,
   output logic [1:0] lanes_seen,
   output logic [7:0] starts_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // The framer only trusts the setup at the moment the buffers start.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         frames_seen <= 6'h00;
         octets_seen <= 3'h0;
         lanes_seen <= 2'h0;
         starts_seen <= 8'h00;
      end else if (lane_buffer_start_pulse) begin
         frames_seen <= {1'b0, cfg_frames_per_multiframe} + 6'h01;
         octets_seen <= (cfg_octets_per_frame == 8'h01) ? 3'h2 :
            (cfg_octets_per_frame == 8'h03) ? 3'h4 : 3'h0;
         lanes_seen <= (cfg_lane_count == 5'h00) ? 2'h1 : 2'h2;
         starts_seen <= starts_seen + 8'h01;
      end
   end
endmodule : jlp_framer_model

`default_nettype wire

// ==== dv/jlp_link_param_regs_test.sv ====
// Self-checking bench for the link parameter bank.
`include "jlp_params.svh"
`default_nettype none

module jlp_link_param_regs_test
   import jlp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, avs_read, avs_write, avs_waitrequest;
   logic [`JLP_ADDR_W-1:0] avs_address;
   logic [`JLP_DATA_W-1:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, cfg_bank_id;
   logic [1:0] avs_response, lane_buffer_run, lanes_seen;
   logic [7:0] cfg_device_id, cfg_octets_per_frame, cfg_converter_count, starts_seen;
   logic [7:0] cfg_spare_param_byte_one, cfg_spare_param_byte_two;
   logic [7:0] cfg_lane0_checksum, cfg_lane1_checksum;
   logic [4:0] cfg_lane_count, cfg_frames_per_multiframe, cfg_samples_per_frame;
   logic [4:0] cfg_lane0_id, cfg_lane1_id;
   logic cfg_scramble_en, lane_buffer_start, lane_buffer_start_pulse;
   logic [5:0] frames_seen;
   logic [2:0] octets_seen;
   int errors, n_checks, cycles;
   logic [9:0] adr_t [14] = '{10'h1c0, 10'h1c1, 10'h1c3, 10'h1c4, 10'h1c5, 10'h1c6, 10'h1c9,
      10'h1cb, 10'h1cc, 10'h1d0, 10'h1d1, 10'h1d8, 10'h1d9, 10'h1e0};
   jlp_byte_t rst_t [14] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h1f, 8'h01, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h01, 8'h44, 8'h45, 8'h00};

   jlp_link_param_regs #(.LANES(2)) jlp_link_param_regs_i (.mclk, .rstn, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
      .avs_waitrequest, .cfg_device_id, .cfg_bank_id, .cfg_lane_count, .cfg_scramble_en,
      .cfg_octets_per_frame, .cfg_frames_per_multiframe, .cfg_converter_count,
      .cfg_samples_per_frame, .cfg_spare_param_byte_one, .cfg_spare_param_byte_two,
      .cfg_lane0_id, .cfg_lane1_id, .cfg_lane0_checksum, .cfg_lane1_checksum,
      .lane_buffer_start, .lane_buffer_run, .lane_buffer_start_pulse);
   jlp_framer_model jlp_framer_model_i (.mclk, .rstn, .cfg_lane_count, .cfg_octets_per_frame,
      .cfg_frames_per_multiframe, .lane_buffer_start_pulse, .frames_seen, .octets_seen,
      .lanes_seen, .starts_seen);

   // ****************************************************************
   // Clock, timeout and reporting
   // ****************************************************************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // The request is held until waitrequest is seen low; outputs are judged at the
   // following falling edge so that the landing write has settled.
   task automatic bus(input logic wr, input logic [9:0] a, input jlp_byte_t d,
         input logic [1:0] exp_rs, input logic chk_rd, input jlp_byte_t exp);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'h1;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge mclk);
      end while (avs_waitrequest !== 1'b0);
      chk("response", {38'h0, avs_response}, {38'h0, exp_rs});
      if (chk_rd) begin
         chk("read data", {8'h0, avs_readdata}, {32'h0, exp});
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge mclk);
   endtask : bus

   task automatic outs(input logic [39:0] a, input logic [39:0] b, input logic [39:0] c);
      chk("outputs a", {9'h0, cfg_device_id, cfg_bank_id, cfg_lane_count, cfg_scramble_en,
         cfg_octets_per_frame, cfg_frames_per_multiframe}, a);
      chk("outputs b", {6'h0, cfg_converter_count, cfg_lane0_id, cfg_lane1_id,
         cfg_lane0_checksum, cfg_lane1_checksum}, b);
      chk("outputs c", {15'h0, cfg_spare_param_byte_one, cfg_spare_param_byte_two,
         cfg_samples_per_frame, lane_buffer_start, lane_buffer_run,
         lane_buffer_start_pulse}, c);
   endtask : outs

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset_values();
      @(negedge mclk);
      outs({8'h00, 4'h0, 5'h00, 1'b0, 8'h03, 5'h1f}, {8'h01, 5'h00, 5'h01, 8'h44, 8'h45},
         {8'h00, 8'h00, 5'h00, 1'b0, 2'b00, 1'b0});
      foreach (adr_t[i]) begin
         bus(1'b0, adr_t[i], 8'h00, 2'h0, 1'b1, rst_t[i]);
      end
   endtask : t_reset_values

   // Inverted reset values touch every bit except the low five of the samples byte; the start bit goes last of all.
   task automatic t_write_all();
      foreach (adr_t[i]) begin
         bus(1'b1, adr_t[i], ~rst_t[i] & (i == 6 ? 8'he0 : 8'hff), 2'h0, 1'b0,
            8'h00);
      end
      foreach (adr_t[i]) begin
         bus(1'b0, adr_t[i], 8'h00, 2'h0, 1'b1,
            ~rst_t[i] & (i == 1 ? 8'h0f : i == 6 ? 8'he0 : 8'hff));
      end
      outs({8'hff, 4'hf, 5'h1f, 1'b1, 8'hfc, 5'h00}, {8'hfe, 5'h1f, 5'h1e, 8'hbb, 8'hba},
         {8'hff, 8'hff, 5'h00, 1'b1, 2'b11, 1'b0});
      chk("frames at start", {34'h0, frames_seen}, 40'h01);
   endtask : t_write_all

   task automatic t_start(input jlp_byte_t l, input jlp_byte_t o, input logic [1:0] run,
         input logic [2:0] oct, input logic [1:0] lanes);
      logic [7:0] n;
      n = starts_seen;
      bus(1'b1, 10'h1c3, l, 2'h0, 1'b0, 8'h00);
      bus(1'b1, 10'h1c4, o, 2'h0, 1'b0, 8'h00);
      bus(1'b1, 10'h1c5, 8'h1f, 2'h0, 1'b0, 8'h00);
      chk("lane field", {34'h0, cfg_scramble_en, cfg_lane_count},
         {34'h0, l[7], l[4:0]});
      bus(1'b1, 10'h1e0, 8'h01, 2'h0, 1'b0, 8'h00);
      @(negedge mclk);
      chk("run", {38'h0, lane_buffer_run}, {38'h0, run});
      @(negedge mclk);
      chk("starts", {32'h0, starts_seen}, {32'h0, n + 8'h01});
      chk("setup", {29'h0, frames_seen, octets_seen, lanes_seen},
         {29'h0, 6'h20, oct, lanes});
      bus(1'b0, 10'h1ef, 8'h00, 2'h0, 1'b1, {6'h0, run});
      bus(1'b1, 10'h1e0, 8'h00, 2'h0, 1'b0, 8'h00);
      @(negedge mclk);
      chk("run stopped", {38'h0, lane_buffer_run}, 40'h0);
   endtask : t_start

   task automatic t_unmapped();
      bus(1'b0, 10'h1c2, 8'h00, 2'h2, 1'b1, 8'h00);
      bus(1'b1, 10'h1c2, 8'h5a, 2'h2, 1'b0, 8'h00);
      bus(1'b1, 10'h1ef, 8'h5a, 2'h2, 1'b0, 8'h00);
   endtask : t_unmapped

   initial begin
      errors = 0;
      n_checks = 0;
      cycles = 0;
      rstn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      avs_byteenable = 4'h0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_values();
      t_write_all();
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_values();
      t_start(8'h80, 8'h03, 2'b01, 3'h4, 2'h1);
      t_start(8'h01, 8'h01, 2'b11, 3'h2, 2'h2);
      t_unmapped();
      stop_test();
   end
endmodule : jlp_link_param_regs_test

`default_nettype wire

// ==== dv/jlp_regs_asserts.sv ====
// Port checker for the link parameter bank.
`include "jlp_params.svh"
`default_nettype none

module jlp_regs_chk
   import jlp_pkg::*;
#(
   parameter int LANES = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [`JLP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`JLP_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [`JLP_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [7:0] cfg_device_id,
   input wire logic [4:0] cfg_lane_count,
   input wire logic cfg_scramble_en,
   input wire logic [7:0] cfg_octets_per_frame,
   input wire logic [4:0] cfg_frames_per_multiframe,
   input wire logic [7:0] cfg_converter_count,
   input wire logic [4:0] cfg_lane1_id,
   input wire logic [7:0] cfg_lane0_checksum,
   input wire logic lane_buffer_start,
   input wire logic [LANES-1:0] lane_buffer_run,
   input wire logic lane_buffer_start_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_done;
   assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_lane_field:
      assert property (wr_done && avs_address == `JLP_IDX_LANE_CNT |=>
         {cfg_scramble_en, 2'h0, cfg_lane_count} == ($past(avs_writedata) & 32'h9f))
      else $error("lane count field not loaded");
   a_octets_load:
      assert property (wr_done && avs_address == `JLP_IDX_OCTETS |=>
         cfg_octets_per_frame == ($past(avs_writedata) & 32'hff))
      else $error("octets field not loaded");
   a_frames_load:
      assert property (wr_done && avs_address == `JLP_IDX_FRAMES_MF |=>
         cfg_frames_per_multiframe == ($past(avs_writedata) & 32'h1f))
      else $error("frames field not loaded");
   a_conv_load:
      assert property (wr_done && avs_address == `JLP_IDX_CONV_CNT |=>
         cfg_converter_count == ($past(avs_writedata) & 32'hff))
      else $error("converter field not loaded");
   a_bank_upper:
      assert property (avs_read && !avs_waitrequest && avs_address == `JLP_IDX_BANK_ID
         |-> avs_readdata[7:4] == 4'h0)
      else $error("bank id upper nibble not zero");
   a_lane_id:
      assert property (wr_done && avs_address == `JLP_IDX_LANE1_ID |=>
         cfg_lane1_id == ($past(avs_writedata) & 32'h1f))
      else $error("lane one id not loaded");
   a_checksum_load:
      assert property (wr_done && avs_address == `JLP_IDX_LANE0_CHK |=>
         cfg_lane0_checksum == ($past(avs_writedata) & 32'hff))
      else $error("lane zero checksum not loaded");
   a_start_pulse:
      assert property ($rose(lane_buffer_start) |=>
         lane_buffer_start_pulse && lane_buffer_run[0] ##1 !lane_buffer_start_pulse)
      else $error("start pulse or run wrong");
   a_run_stop:
      assert property (!lane_buffer_start |=> !lane_buffer_run[0] && !lane_buffer_run[1])
      else $error("lanes run without start");
   a_two_lanes:
      assert property (lane_buffer_start && cfg_lane_count != 5'h00 |=> lane_buffer_run[1])
      else $error("second lane not running");
   a_cfg_hold:
      assert property (!wr_done |=> $stable(cfg_device_id) && $stable(cfg_lane_count)
         && $stable(cfg_octets_per_frame) && $stable(cfg_lane0_checksum))
      else $error("setup changed without a write");
endmodule : jlp_regs_chk

bind jlp_link_param_regs jlp_regs_chk #(.LANES(LANES)) jlp_regs_chk_i (.mclk, .rstn,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .cfg_device_id, .cfg_lane_count, .cfg_scramble_en,
   .cfg_octets_per_frame, .cfg_frames_per_multiframe, .cfg_converter_count, .cfg_lane1_id,
   .cfg_lane0_checksum, .lane_buffer_start, .lane_buffer_run, .lane_buffer_start_pulse);

`default_nettype wire
